// File: logic/led_regs_pkg.sv
package led_regs_pkg;
    localparam int data_width = 8;
    localparam int pointer_width = 5;
    localparam logic [4:0] mode_control_one_offset = 5'h00;
    localparam logic [4:0] secondary_address_one_offset = 5'h18;
    localparam logic [4:0] secondary_address_two_offset = 5'h19;
    localparam logic [4:0] secondary_address_three_offset = 5'h1A;
    localparam logic [4:0] broadcast_led_address_offset = 5'h1B;
    localparam logic [4:0] last_valid_pointer = 5'h1B;
    localparam int autoinc_enable_bit = 7;
    localparam int autoinc_option_hi_bit = 6;
    localparam int autoinc_option_lo_bit = 5;
    localparam int sleep_bit = 4;
    localparam int secondary_one_enable_bit = 3;
    localparam int secondary_two_enable_bit = 2;
    localparam int secondary_three_enable_bit = 1;
    localparam int broadcast_enable_bit = 0;
    localparam logic [7:0] mode_control_one_reset = 8'h91;
    localparam logic [7:0] mode_control_one_write_mask = 8'h1F;
    localparam logic [6:0] secondary_address_one_reset = 7'h00;
    localparam logic [6:0] secondary_address_two_reset = 7'h00;
    localparam logic [6:0] secondary_address_three_reset = 7'h00;
    localparam logic [6:0] broadcast_led_address_reset = 7'h00;
    localparam int clock_mhz = 100;
    localparam int oscillator_startup_us = 500;
    localparam int oscillator_startup_cycles = oscillator_startup_us * clock_mhz;
endpackage

// File: logic/led_driver_mode_and_address_regs.sv
// Summary of operation
// - Acknowledge pointer values 00h through 1Bh
// - Refuse reserved pointers 1Ch through 1Fh
// - Three secondary address registers at 18h-1Ah
// - Broadcast address register at 1Bh, read/write
// - Mode bits 7..5 read-only, reset 100
// - Sleep bit stops oscillator, resets to one
// - Bits 3..1 enable secondary addresses, reset zero
// - Bit 0 enables broadcast address, reset one
// - Oscillator running within 500 us of change
// - No dimming or blinking while oscillator stopped
`timescale 1ns/1ns
module led_driver_mode_and_address_regs
    import led_regs_pkg::*;
#(
    parameter int startup_cycles = oscillator_startup_cycles
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pointer_valid,
    input wire logic [led_regs_pkg::pointer_width-1:0] pointer_value,
    input wire logic write_strobe,
    input wire logic [led_regs_pkg::data_width-1:0] write_data,
    input wire logic [6:0] bus_address,
    output logic pointer_ack,
    output logic [led_regs_pkg::data_width-1:0] read_data,
    output logic oscillator_enable,
    output logic oscillator_ready,
    output logic dimming_blinking_allowed,
    output logic secondary_one_match,
    output logic secondary_two_match,
    output logic secondary_three_match,
    output logic broadcast_match
);
    import led_regs_pkg::*;

    logic [4:0] pointer;
    logic [7:0] mode_control_one;
    logic [6:0] secondary_address_one;
    logic [6:0] secondary_address_two;
    logic [6:0] secondary_address_three;
    logic [6:0] broadcast_led_address;
    logic [31:0] startup_count;
    logic sleep_seen;
    logic [7:0] next_read_data;

    function automatic logic pointer_ok(input logic [4:0] value);
        pointer_ok = (value <= last_valid_pointer);
    endfunction

    // Same compare for all four extra addresses: enable bit and stored address
    function automatic logic address_hit(
        input logic enable,
        input logic [6:0] stored,
        input logic [6:0] incoming
    );
        address_hit = enable && (incoming == stored);
    endfunction

    // Bits 7..5 of the control byte never reach this block; only the low five bits select
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pointer <= 5'h00;
            pointer_ack <= 1'b0;
        end
        else
        begin
            pointer_ack <= pointer_valid && pointer_ok(pointer_value);
            if (pointer_valid && pointer_ok(pointer_value))
            begin
                pointer <= pointer_value;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_control_one <= mode_control_one_reset;
        end
        else if (write_strobe && pointer == mode_control_one_offset)
        begin
            // Auto-increment flags stay fixed; writes reach only the low five bits
            mode_control_one <= (mode_control_one_reset & ~mode_control_one_write_mask)
                | (write_data & mode_control_one_write_mask);
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            secondary_address_one <= secondary_address_one_reset;
            secondary_address_two <= secondary_address_two_reset;
            secondary_address_three <= secondary_address_three_reset;
            broadcast_led_address <= broadcast_led_address_reset;
        end
        else if (write_strobe)
        begin
            // Bit 0 of an address byte is the read/write position and is not stored
            case (pointer)
                secondary_address_one_offset: secondary_address_one <= write_data[7:1];
                secondary_address_two_offset: secondary_address_two <= write_data[7:1];
                secondary_address_three_offset: secondary_address_three <= write_data[7:1];
                broadcast_led_address_offset: broadcast_led_address <= write_data[7:1];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        next_read_data = 8'h00;
        case (pointer)
            mode_control_one_offset: next_read_data = mode_control_one;
            secondary_address_one_offset: next_read_data = {secondary_address_one, 1'b0};
            secondary_address_two_offset: next_read_data = {secondary_address_two, 1'b0};
            secondary_address_three_offset: next_read_data = {secondary_address_three, 1'b0};
            broadcast_led_address_offset: next_read_data = {broadcast_led_address, 1'b0};
            default: next_read_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            read_data <= 8'h00;
        end
        else
        begin
            read_data <= next_read_data;
        end
    end

    // Last cycle's sleep bit; resets high like the bit, so no false wake follows reset
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sleep_seen <= 1'b1;
        end
        else
        begin
            sleep_seen <= mode_control_one[sleep_bit];
        end
    end

    // Count saturates at the end of the window so a long run never wraps
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            startup_count <= 32'h00000000;
        end
        else if (mode_control_one[sleep_bit])
        begin
            startup_count <= 32'h00000000;
        end
        else if (sleep_seen)
        begin
            startup_count <= 32'h00000001;
        end
        else if (startup_count < 32'(startup_cycles - 1))
        begin
            startup_count <= startup_count + 32'h00000001;
        end
    end

    // Ready waits out the whole start-up window; it is pessimistic but never early
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oscillator_ready <= 1'b0;
        end
        else if (mode_control_one[sleep_bit] || sleep_seen)
        begin
            oscillator_ready <= 1'b0;
        end
        else if (startup_count >= 32'(startup_cycles - 1))
        begin
            oscillator_ready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            oscillator_enable <= 1'b0;
        end
        else
        begin
            oscillator_enable <= !mode_control_one[sleep_bit];
        end
    end

    // Group effects stop the moment sleep is set, not when the oscillator decays
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dimming_blinking_allowed <= 1'b0;
        end
        else
        begin
            dimming_blinking_allowed <= !mode_control_one[sleep_bit];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            secondary_one_match <= 1'b0;
            secondary_two_match <= 1'b0;
            secondary_three_match <= 1'b0;
            broadcast_match <= 1'b0;
        end
        else
        begin
            secondary_one_match <= address_hit(mode_control_one[secondary_one_enable_bit],
                secondary_address_one, bus_address);
            secondary_two_match <= address_hit(mode_control_one[secondary_two_enable_bit],
                secondary_address_two, bus_address);
            secondary_three_match <= address_hit(mode_control_one[secondary_three_enable_bit],
                secondary_address_three, bus_address);
            broadcast_match <= address_hit(mode_control_one[broadcast_enable_bit],
                broadcast_led_address, bus_address);
        end
    end
endmodule

// File: dv/led_regs_chk.sv
`timescale 1ns/1ns
module led_regs_chk
    import led_regs_pkg::*;
#(
    parameter int startup_cycles = oscillator_startup_cycles
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pointer_valid,
    input wire logic [4:0] pointer_value,
    input wire logic write_strobe,
    input wire logic [7:0] write_data,
    input wire logic pointer_ack,
    input wire logic [7:0] read_data,
    input wire logic oscillator_enable,
    input wire logic oscillator_ready,
    input wire logic dimming_blinking_allowed,
    input wire logic broadcast_match
);
    logic [31:0] wait_count;
    logic [4:0] ptr;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) wait_count <= '0;
        else if (!oscillator_enable || oscillator_ready) wait_count <= '0;
        else wait_count <= wait_count + 1;
    // Mirrors the pointer so the checker knows which register a write lands in
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) ptr <= 5'h00;
        else if (pointer_valid && pointer_value <= 5'h1B) ptr <= pointer_value;
    a_ack_valid: assert property (pointer_valid && pointer_value <= 5'h1B |=> pointer_ack)
        else $error("no ack");
    a_ack_reserved: assert property (pointer_valid && pointer_value > 5'h1B |=> !pointer_ack)
        else $error("ack");
    a_ack_cause: assert property (pointer_ack |-> $past(pointer_valid)) else $error("stray ack");
    a_dim_stopped: assert property (!oscillator_enable |-> !dimming_blinking_allowed)
        else $error("dims");
    a_ready_enable: assert property (oscillator_ready |-> oscillator_enable) else $error("ready asleep");
    a_ready_bound: assert property (wait_count <= startup_cycles + 4) else $error("start slow");
    a_sleep_write: assert property (write_strobe && ptr == 5'h00 |=> ##1
        oscillator_enable == !$past(write_data[4], 2)) else $error("sleep bit");
    a_bcast_off: assert property (write_strobe && ptr == 5'h00 && !write_data[0] |=> ##1
        !broadcast_match) else $error("bcast on");
    a_flags_fixed: assert property ($past(rst_b) && $past(ptr) == 5'h00 |->
        read_data[7:5] == 3'b100) else $error("flags moved");
endmodule
bind led_driver_mode_and_address_regs led_regs_chk #(.startup_cycles(startup_cycles)) chk_inst (.clk(clk),
    .rst_b(rst_b), .pointer_valid(pointer_valid), .pointer_value(pointer_value), .write_strobe(write_strobe),
    .write_data(write_data), .pointer_ack(pointer_ack), .read_data(read_data), .oscillator_enable(oscillator_enable),
    .oscillator_ready(oscillator_ready), .dimming_blinking_allowed(dimming_blinking_allowed),
    .broadcast_match(broadcast_match));

// File: dv/led_bus_master.sv
`timescale 1ns/1ns
module led_bus_master
(
    input wire logic clk,
    output logic pointer_valid,
    output logic [4:0] pointer_value,
    output logic write_strobe,
    output logic [7:0] write_data
);
    initial {pointer_valid, pointer_value, write_strobe, write_data} = '0;
    // Only the five pointer bits reach the block; no other control-byte bit is driven
    task automatic point(input logic [4:0] p);
        @(posedge clk);
        pointer_valid <= 1'b1;
        pointer_value <= p;
        @(posedge clk);
        pointer_valid <= 1'b0;
        pointer_value <= ~p;
    endtask
    task automatic put(input logic [7:0] d);
        @(posedge clk);
        write_strobe <= 1'b1;
        write_data <= d;
        @(posedge clk);
        write_strobe <= 1'b0;
        write_data <= ~d;
    endtask
endmodule

// File: dv/test_led_driver_mode_and_address_regs.sv
`timescale 1ns/1ns
module test_led_driver_mode_and_address_regs;
    import led_regs_pkg::*;
    logic clk = 0, rst_b = 0, pointer_valid, write_strobe, pointer_ack, oscillator_enable, oscillator_ready;
    logic dimming_blinking_allowed, secondary_one_match, secondary_two_match, secondary_three_match;
    logic broadcast_match;
    logic [4:0] pointer_value;
    logic [7:0] write_data, read_data;
    logic [6:0] bus_address = 7'h00;
    int n_errors = 0, comparisons = 0;
    led_bus_master led_bus_master_inst (.clk(clk), .pointer_valid(pointer_valid), .pointer_value(pointer_value),
        .write_strobe(write_strobe), .write_data(write_data));
    led_driver_mode_and_address_regs #(.startup_cycles(20)) led_driver_mode_and_address_regs_inst (.clk(clk),
        .rst_b(rst_b), .pointer_valid(pointer_valid), .pointer_value(pointer_value), .write_strobe(write_strobe),
        .write_data(write_data), .bus_address(bus_address), .pointer_ack(pointer_ack), .read_data(read_data),
        .oscillator_enable(oscillator_enable), .oscillator_ready(oscillator_ready),
        .dimming_blinking_allowed(dimming_blinking_allowed), .secondary_one_match(secondary_one_match),
        .secondary_two_match(secondary_two_match), .secondary_three_match(secondary_three_match),
        .broadcast_match(broadcast_match));
    initial forever #5 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] expected);
        comparisons++;
        if (seen !== expected)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, expected);
        end
    endtask
    task automatic report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic access(input logic [4:0] p, input logic ack);
        led_bus_master_inst.point(p);
        #1 check(pointer_ack, ack);
    endtask
    task automatic reset_state;
        access(5'h00, 1'b1);
        @(posedge clk) #1 check(read_data, 8'h91);
        check({oscillator_enable, dimming_blinking_allowed, broadcast_match}, 3'b001);
        check(oscillator_ready, 1'b0);
    endtask
    task automatic address_regs;
        for (int i = 0; i < 4; i++)
        begin
            access(5'h18 + i[4:0], 1'b1);
            led_bus_master_inst.put(8'hA2 + 8'(i * 16));
            @(posedge clk) #1 check(read_data, 8'hA2 + 8'(i * 16));
        end
        @(posedge clk);
        bus_address <= 7'h61;
        access(5'h00, 1'b1);
        led_bus_master_inst.put(8'hEA);
        @(posedge clk) #1 check(read_data, 8'h8A);
        check({secondary_one_match, secondary_two_match, secondary_three_match, broadcast_match}, 4'h2);
    endtask
    task automatic reserved_and_wake;
        for (int i = 28; i < 32; i++)
            access(i[4:0], 1'b0);
        led_bus_master_inst.put(8'hFF);
        @(posedge clk) #1 check(read_data, 8'h9F);
        check({oscillator_enable, dimming_blinking_allowed, oscillator_ready}, 3'b000);
        led_bus_master_inst.put(8'h00);
        for (int i = 0; i < 30 && !oscillator_ready; i++)
            @(posedge clk) #1;
        check({oscillator_ready, dimming_blinking_allowed}, 2'b11);
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        reset_state();
        address_regs();
        reserved_and_wake();
        report_and_stop();
    end
endmodule
